// file: src/sbg_defines.vh
// Register map, field positions, reset values and divider constants of the baud generator.
// Function
// RQ1 - Noise filter acts only on the receive input and only in asynchronous mode.
// RQ2 - Filter select bit 0 enables, 1 bypasses; it resets to 1.
// RQ3 - Sampling control bits 7 to 3 and 1 to 0 read 1; writes ignored.
// RQ4 - Filter is three cascaded sampling latches plus an all-agree comparator.
// RQ5 - Latches sample at the base clock, sixteen times the transfer clock.
// RQ6 - Agreeing latches pass their level; otherwise the previous output holds.
// RQ7 - Asynchronous, prescale 0 and rate 0 give clock divided by 32.
// RQ8 - Synchronous, prescale 0 and rate 0 give clock divided by 4.
// RQ9 - Software must not expect continuous synchronous transfers at the fastest setting.
// RQ10 - Rate value is an 8-bit writable register that resets to all ones.
// RQ11 - Two-bit prescale select n scales the clock by 2 to the (2n-1).
// RQ12 - Bit rate is clock over (rate+1) times 2^(2n-1) times 64 or 8.
// RQ13 - Receiver takes the filtered level when enabled, else the registered raw input.
`ifndef SBG_DEFINES_VH
`define SBG_DEFINES_VH

`define SBG_ADDR_SERIAL_MODE 8'h00
`define SBG_ADDR_RATE_DIVIDER 8'h04
`define SBG_ADDR_RX_SAMPLING 8'h08
`define SBG_ADDR_STATUS 8'h0C

`define SBG_MODE_RESET 8'h00
`define SBG_RATE_RESET 8'hFF
`define SBG_SAMPLING_RESET 8'hFF
`define SBG_SAMPLING_FIXED 8'hFB

`define SBG_MODE_SYNC_BIT 7
`define SBG_MODE_PSC_HI_BIT 1
`define SBG_MODE_PSC_LO_BIT 0
`define SBG_SAMPLING_BYPASS_BIT 2

`define SBG_PSC_MAX_N0 7'h01
`define SBG_PSC_MAX_N1 7'h07
`define SBG_PSC_MAX_N2 7'h1F
`define SBG_PSC_MAX_N3 7'h7F

`define SBG_ASYNC_TICKS_PER_BIT 5'h10
`define SBG_SYNC_TICKS_PER_BIT 5'h02
`define SBG_FILTER_STAGES 3

`endif

// file: src/sbg_top.v
// Baud-rate generator with selectable receive noise filter and an APB register slave.
`timescale 1ns/1ps
`include "sbg_defines.vh"

module sbg_top
(
   input wire clk_i,
   input wire resetn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire pready_o,
   output reg [31:0] prdata_o,
   output reg pslverr_o,
   input wire rxd_i,
   output reg sample_tick_o,
   output reg bit_tick_o,
   output reg ser_clk_o,
   output reg rx_level_o,
   output reg sync_mode_o
);

   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_n;

   reg [7:0] mode_q;
   reg [7:0] rate_q;
   reg bypass_q;
   reg cfg_wr_q;

   reg [6:0] psc_cnt_q;
   reg [6:0] psc_max;
   reg [7:0] rate_cnt_q;
   reg [4:0] bit_cnt_q;
   wire [4:0] ticks_per_bit;

   reg raw_q;
   reg [`SBG_FILTER_STAGES-1:0] latch_q;
   wire [`SBG_FILTER_STAGES:0] chain_in;
   reg filt_q;
   wire all_high;
   wire all_low;
   wire filter_on;

   wire setup;
   wire wr_en;
   reg [31:0] rdata_d;
   reg err_d;
   wire [1:0] psc_sel;
   wire psc_tick;
   wire base_tick;
   localparam [7:0] SAMPLING_RESET = `SBG_SAMPLING_RESET;

   // Reset is applied at once and released after two clock edges.
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // The slave answers in the first access cycle with data prepared at setup.
   assign pready_o = 1'b1;
   assign setup = psel_i & ~penable_i;
   assign wr_en = psel_i & penable_i & pwrite_i;

   always @*
   begin
      rdata_d = 32'h00000000;
      err_d = 1'b0;
      case (paddr_i)
         `SBG_ADDR_SERIAL_MODE:
         begin
            rdata_d = {24'h000000, mode_q};
         end
         `SBG_ADDR_RATE_DIVIDER:
         begin
            rdata_d = {24'h000000, rate_q};
         end
         `SBG_ADDR_RX_SAMPLING:
         begin
            rdata_d = {24'h000000, `SBG_SAMPLING_FIXED | {5'h00, bypass_q, 2'h0}}; // RQ3
         end
         `SBG_ADDR_STATUS:
         begin
            rdata_d = {29'h00000000, filter_on, raw_q, rx_level_o};
         end
         default:
         begin
            err_d = 1'b1;
         end
      endcase
   end

   always @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
      end
      else if (setup)
      begin
         prdata_o <= pwrite_i ? 32'h00000000 : rdata_d;
         pslverr_o <= err_d;
      end
   end

   // Configuration registers; the status word is read-only.
   always @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= `SBG_MODE_RESET;
         rate_q <= `SBG_RATE_RESET; // RQ10
         bypass_q <= SAMPLING_RESET[`SBG_SAMPLING_BYPASS_BIT]; // RQ2
         cfg_wr_q <= 1'b0;
      end
      else
      begin
         cfg_wr_q <= 1'b0;
         if (wr_en)
         begin
            case (paddr_i)
               `SBG_ADDR_SERIAL_MODE:
               begin
                  mode_q <= {pwdata_i[`SBG_MODE_SYNC_BIT], 5'h00,
                             pwdata_i[`SBG_MODE_PSC_HI_BIT:`SBG_MODE_PSC_LO_BIT]}; // RQ11
                  cfg_wr_q <= 1'b1;
               end
               `SBG_ADDR_RATE_DIVIDER:
               begin
                  rate_q <= pwdata_i[7:0]; // RQ10
                  cfg_wr_q <= 1'b1;
               end
               `SBG_ADDR_RX_SAMPLING:
               begin
                  bypass_q <= pwdata_i[`SBG_SAMPLING_BYPASS_BIT]; // RQ2 RQ3
               end
               default:
               begin
                  cfg_wr_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Prescaler divides by 2^(2n+1), taking a factor of four from the 64 or 8, so the chain counts 16 or 2.
   assign psc_sel = mode_q[`SBG_MODE_PSC_HI_BIT:`SBG_MODE_PSC_LO_BIT];

   always @*
   begin
      case (psc_sel)
         2'h0: psc_max = `SBG_PSC_MAX_N0; // RQ11
         2'h1: psc_max = `SBG_PSC_MAX_N1;
         2'h2: psc_max = `SBG_PSC_MAX_N2;
         2'h3: psc_max = `SBG_PSC_MAX_N3;
         default: psc_max = `SBG_PSC_MAX_N0;
      endcase
   end

   assign ticks_per_bit = mode_q[`SBG_MODE_SYNC_BIT] ? `SBG_SYNC_TICKS_PER_BIT :
                          `SBG_ASYNC_TICKS_PER_BIT; // RQ7 RQ8 RQ12

   assign psc_tick = (psc_cnt_q == psc_max);
   assign base_tick = psc_tick && (rate_cnt_q == rate_q);

   // A write to the mode or rate register restarts every divider stage from zero.
   always @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         psc_cnt_q <= 7'h00;
         rate_cnt_q <= 8'h00;
         bit_cnt_q <= 5'h00;
         sample_tick_o <= 1'b0;
         bit_tick_o <= 1'b0;
         ser_clk_o <= 1'b0;
         sync_mode_o <= 1'b0;
      end
      else if (cfg_wr_q)
      begin
         psc_cnt_q <= 7'h00;
         rate_cnt_q <= 8'h00;
         bit_cnt_q <= 5'h00;
         sample_tick_o <= 1'b0;
         bit_tick_o <= 1'b0;
         ser_clk_o <= 1'b0;
         sync_mode_o <= mode_q[`SBG_MODE_SYNC_BIT];
      end
      else
      begin
         sync_mode_o <= mode_q[`SBG_MODE_SYNC_BIT];
         sample_tick_o <= base_tick; // RQ5
         bit_tick_o <= 1'b0;
         psc_cnt_q <= psc_tick ? 7'h00 : psc_cnt_q + 7'h01;
         if (psc_tick)
         begin
            rate_cnt_q <= (rate_cnt_q == rate_q) ? 8'h00 : rate_cnt_q + 8'h01; // RQ12
         end
         if (base_tick)
         begin
            if (bit_cnt_q == ticks_per_bit - 5'h01)
            begin
               bit_cnt_q <= 5'h00;
               bit_tick_o <= 1'b1; // RQ7 RQ8
            end
            else
            begin
               bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            // Serial clock is high in the second half of each bit period.
            ser_clk_o <= (bit_cnt_q == (ticks_per_bit >> 1) - 5'h01) ? 1'b1 :
                         (bit_cnt_q == ticks_per_bit - 5'h01) ? 1'b0 : ser_clk_o;
         end
      end
   end

   // Receive input is registered once before the filter and the bypass path.
   always @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_q <= 1'b1;
      end
      else
      begin
         raw_q <= rxd_i;
      end
   end

   assign filter_on = ~bypass_q & ~mode_q[`SBG_MODE_SYNC_BIT]; // RQ1 RQ2
   // Stage zero takes the registered input, every later stage the one before it.
   assign chain_in = {latch_q, raw_q}; // RQ4

   genvar gi;
   generate
      for (gi = 0; gi < `SBG_FILTER_STAGES; gi = gi + 1)
      begin : g_latch
         always @(posedge clk_i or negedge rst_n)
         begin
            if (!rst_n)
            begin
               latch_q[gi] <= 1'b1;
            end
            else if (sample_tick_o)
            begin
               latch_q[gi] <= chain_in[gi]; // RQ4 RQ5
            end
         end
      end
   endgenerate

   assign all_high = &latch_q; // RQ4
   assign all_low = ~|latch_q; // RQ4

   always @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         filt_q <= 1'b1;
      end
      else if (all_high)
      begin
         filt_q <= 1'b1; // RQ6
      end
      else if (all_low)
      begin
         filt_q <= 1'b0; // RQ6
      end
   end

   // The receiver sees the filter output only while the filter is in use.
   always @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_level_o <= 1'b1;
      end
      else
      begin
         rx_level_o <= filter_on ? filt_q : raw_q; // RQ13 RQ1
      end
   end

endmodule

// file: verification/sbg_top_sva.sv
// Port-level checker for the baud generator and the APB register slave.
`timescale 1ns/1ps
module sbg_chk
(
   input wire clk_i,
   input wire resetn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire pready_o,
   input wire [31:0] prdata_o,
   input wire pslverr_o,
   input wire sample_tick_o,
   input wire bit_tick_o,
   input wire sync_mode_o
);
   wire wr0 = psel_i && penable_i && pwrite_i && paddr_i == 8'h00;
   wire setup = psel_i && !penable_i;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   sequence s_quiet3;
      !bit_tick_o [*3];
   endsequence
   property p_tick; sample_tick_o |=> !sample_tick_o; endproperty
   property p_bit; bit_tick_o |-> sample_tick_o; endproperty
   property p_gap; bit_tick_o |=> s_quiet3; endproperty
   property p_mode; $changed(sync_mode_o) |-> $past(wr0) || $past(wr0, 2); endproperty
   property p_samp;
      setup && !pwrite_i && paddr_i == 8'h08 |=> prdata_o[7:3] == 5'h1F && prdata_o[1:0] == 2'h3;
   endproperty
   property p_err; setup && paddr_i > 8'h0C |=> pslverr_o && prdata_o == 32'h0; endproperty
   property p_hi; setup |=> prdata_o[31:8] == 24'h0; endproperty
   property p_rdy; pready_o; endproperty
   a_tick: assert property (p_tick) else $error("sample tick longer than one cycle");
   a_bit: assert property (p_bit) else $error("bit tick without sample tick");
   a_gap: assert property (p_gap) else $error("bit ticks too close");
   a_mode: assert property (p_mode) else $error("mode changed without write");
   a_samp: assert property (p_samp) else $error("reserved bits not one");
   a_err: assert property (p_err) else $error("unmapped access not refused");
   a_hi: assert property (p_hi) else $error("upper read bits not zero");
   a_rdy: assert property (p_rdy) else $error("ready low");
endmodule
bind sbg_top sbg_chk chk (.*);

// file: verification/test_sbg_top.sv
// Self-checking bench for the baud generator and receive filter.
`timescale 1ns/1ps
module test_sbg_top;
   reg clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
   reg pwrite_i = 1'b0, rxd_i = 1'b1, er, lo;
   reg [7:0] paddr_i = 8'h00;
   reg [31:0] pwdata_i = 32'h0, rd;
   wire pready_o, pslverr_o, sample_tick_o, bit_tick_o, ser_clk_o, rx_level_o, sync_mode_o;
   wire [31:0] prdata_o;
   integer fails = 0, n_tests = 0;
   sbg_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i), .sample_tick_o(sample_tick_o),
      .bit_tick_o(bit_tick_o), .ser_clk_o(ser_clk_o), .rx_level_o(rx_level_o),
      .sync_mode_o(sync_mode_o));
   always #25 clk_i = ~clk_i;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp)
         begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         psel_i <= 1'b1;
         penable_i <= 1'b0;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clk_i);
         penable_i <= 1'b1;
         @(posedge clk_i);
         while (pready_o !== 1'b1)
            @(posedge clk_i);
         rd = prdata_o;
         er = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task rdchk(input [7:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(rd, exp);
      end
   endtask
   // Counts clocks from one bit tick to the next, and those with the serial clock high.
   task per(output integer n, output integer h);
      begin
         @(posedge clk_i);
         while (bit_tick_o !== 1'b1)
            @(posedge clk_i);
         @(posedge clk_i);
         n = 1;
         h = ser_clk_o;
         while (bit_tick_o !== 1'b1)
         begin
            @(posedge clk_i);
            n = n + 1;
            h = h + ser_clk_o;
         end
      end
   endtask
   // Drives the receive input low for w clocks and notes any low at the receiver side.
   task pulse(input integer w);
      integer k;
      begin
         lo = 1'b0;
         for (k = 0; k < w + 12; k = k + 1)
         begin
            @(posedge clk_i);
            rxd_i <= (k >= w);
            if (rx_level_o !== 1'b1)
               lo = 1'b1;
         end
      end
   endtask
   task t_reset;
      begin
         chk(sync_mode_o, 1'b0);
         rdchk(8'h00, 32'h0);
         rdchk(8'h04, 32'hFF);
         rdchk(8'h08, 32'hFF);
         apb(1'b0, 8'h10, 32'h0);
         chk(er, 1'b1);
         chk(rd, 32'h0);
      end
   endtask
   task t_rate;
      integer i, n, h, e;
      reg [15:0] c;
      begin
         for (i = 0; i < 5; i = i + 1)
         begin
            case (i)
               0: c = 16'h0000;
               1: c = 16'h8000;
               2: c = 16'h0102;
               3: c = 16'h8301;
               default: c = 16'h0200;
            endcase
            apb(1'b1, 8'h00, {24'h0, c[15:8]});
            apb(1'b1, 8'h04, {24'h0, c[7:0]});
            rdchk(8'h04, {24'h0, c[7:0]});
            per(n, h);
            per(n, h);
            e = ((c[7:0] + 32'h1) << (2 * c[9:8])) * (c[15] ? 4 : 32);
            chk(n, e);
            chk(h, e / 2);
            chk(sync_mode_o, c[15]);
         end
      end
   endtask
   task t_filter;
      begin
         apb(1'b1, 8'h00, 32'h0);
         apb(1'b1, 8'h04, 32'h0);
         apb(1'b1, 8'h08, 32'h0);
         rdchk(8'h08, 32'hFB);
         rdchk(8'h0C, 32'h7);
         pulse(3);
         chk(lo, 1'b0);
         pulse(8);
         chk({lo, rx_level_o}, 2'h3);
         apb(1'b1, 8'h08, 32'hFFFFFFFF);
         pulse(1);
         chk(lo, 1'b1);
         apb(1'b1, 8'h00, 32'h80);
         apb(1'b1, 8'h08, 32'h0);
         rdchk(8'h0C, 32'h3);
         pulse(1);
         chk(lo, 1'b1);
      end
   endtask
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial
   begin
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_reset;
      t_rate;
      t_filter;
      close_out;
   end
   initial
   begin
      #2000000;
      fails = fails + 1;
      close_out;
   end
endmodule
